// ### hw/rsf_pkg.sv
// Package for the remote speed-setting block: register map, field layout, timing.
// Assumes a 125 MHz system clock.
package rsf_pkg;
	localparam int          RSF_FW          = 16;
	localparam int          RSF_CLK_MHZ     = 125;
	localparam longint      RSF_MINUTE_S    = 60;
	localparam longint      RSF_MINUTE_CYC  = RSF_MINUTE_S * 64'd1000000 * RSF_CLK_MHZ;
	localparam logic [7:0]  RSF_A_CTRL      = 8'h00;
	localparam logic [7:0]  RSF_A_MAXF      = 8'h04;
	localparam logic [7:0]  RSF_A_TIMES     = 8'h08;
	localparam logic [7:0]  RSF_A_TIMES2    = 8'h0C;
	localparam logic [7:0]  RSF_A_EXTF      = 8'h10;
	localparam logic [7:0]  RSF_A_REMF      = 8'h14;
	localparam logic [7:0]  RSF_A_STORED    = 8'h18;
	localparam logic [7:0]  RSF_A_STATUS    = 8'h1C;
	localparam logic [7:0]  RSF_A_RAMP      = 8'h20;
	localparam int          RSF_CTRL_SEL_LO = 0;
	localparam int          RSF_CTRL_SEL_HI = 1;
	localparam int          RSF_CTRL_MODE_LO = 4;
	localparam int          RSF_CTRL_MODE_HI = 6;
	localparam int          RSF_CTRL_NET    = 8;
	localparam logic [1:0]  RSF_SEL_MULTI   = 2'h0;
	localparam logic [1:0]  RSF_SEL_STORE   = 2'h1;
	localparam logic [1:0]  RSF_SEL_CLRSTOP = 2'h3;
	localparam logic [2:0]  RSF_MODE_EXT    = 3'h2;
	localparam logic [2:0]  RSF_MODE_COMB4  = 3'h4;
	localparam logic [15:0] RSF_MAXF_RST    = 16'h1770;
	localparam logic [15:0] RSF_TIME_RST    = 16'h0032;
	localparam logic [15:0] RSF_STEP        = 16'h0001;
	localparam logic [31:0] RSF_TICK_DIV    = 32'h0001E848;
endpackage : rsf_pkg

// ### hw/rsf_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous input levels.
`timescale 1ns/100ps
`default_nettype none
module rsf_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, o_ff;
	logic [W-1:0] nxt_o;
	always_comb begin
		nxt_o = o_ff;
		for (int i = 0; i < W; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_o[i] = s2_ff[i];
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			o_ff  <= '0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			o_ff  <= nxt_o;
		end
	end
	assign dout = o_ff;
endmodule : rsf_sync
`default_nettype wire

// ### hw/rsf_top.sv
// Remote speed-setting logic: contact inputs to remote frequency, storage control.
// Assumes an APB master, an external NVM write port and a 125 MHz clock.
// Contract
// - Selection 1..3 maps up, down, clear inputs to accel, decel, clear.
// - Nonzero selection disables multi-speed decoding of the three inputs.
// - Only selection 1 keeps frequency in NVM and restores it at power-up; selection resets to 0, so power-up loads NVM into the stored value only.
// - Store frequency when a start input goes inactive, storage enabled.
// - Up and down idle: compare every minute, write only if different.
// - Periodic store ignores the clear input level.
// - Store when supply changes to external 24V while a start is active.
// - Adjustment limited 0..maximum; total limited to main plus maximum.
// - Second selector off: use second times or longer normal times.
// - Second selector on: use second times regardless of normal times.
// - Up and down change the preset frequency even without start.
// - Remote function disabled during jog or PID control.
// - Power return within one minute of clear restores previous stored value.
// - Power return after one minute runs at the cleared value.
// - In external operation add adjustment to external frequency command.
// - Remote function also available in network operation.
`timescale 1ns/100ps
`default_nettype none
module rsf_top
	import rsf_pkg::*;
#(
	parameter longint MINUTE_CYC = rsf_pkg::RSF_MINUTE_CYC,
	parameter int     TICK_DIV   = int'(rsf_pkg::RSF_TICK_DIV)
) (
	// Clock and reset
	input  wire logic          CLK,
	input  wire logic          RSTN,
	// APB slave
	input  wire logic          PSEL,
	input  wire logic          PENABLE,
	input  wire logic          PWRITE,
	input  wire logic [7:0]    PADDR,
	input  wire logic [31:0]   PWDATA,
	output logic      [31:0]   PRDATA,
	output logic               PREADY,
	output logic               PSLVERR,
	// Contact and start inputs
	input  wire logic          UP_INPUT,
	input  wire logic          DOWN_INPUT,
	input  wire logic          CLEAR_INPUT,
	input  wire logic          FWD_START,
	input  wire logic          REV_START,
	input  wire logic          SECOND_ACCEL_SELECT,
	input  wire logic          JOG_ACTIVE,
	input  wire logic          PID_ACTIVE,
	input  wire logic          EXT24_SUPPLY,
	// Non-volatile memory
	input  wire logic [15:0]   NVM_RDATA,
	output logic               NVM_WE,
	output logic      [15:0]   NVM_WDATA,
	// Frequency command path
	output logic      [15:0]   FREQ_CMD,
	output logic      [15:0]   RAMP_TIME,
	output logic               MULTI_SPEED_EN
);
	initial begin
		if (TICK_DIV < 1 || MINUTE_CYC < 2) begin
			$error("rsf_top: bad timing parameters");
		end
	end
	localparam logic [39:0] MIN_CNT = 40'(MINUTE_CYC - 1);
	localparam logic [31:0] TDIV    = 32'(TICK_DIV - 1);

	logic [5:0] pins;
	logic up, dn, clr, fwd, rev, sec;
	rsf_sync #(.W(6)) u_sync (
		.clk   (CLK),
		.rst_n (RSTN),
		.din   ({UP_INPUT, DOWN_INPUT, CLEAR_INPUT, FWD_START, REV_START, SECOND_ACCEL_SELECT}),
		.dout  (pins)
	);
	assign {up, dn, clr, fwd, rev, sec} = pins;
	logic [2:0] sys_s1_ff, sys_s2_ff, sys_s3_ff, sys_ff;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sys_s1_ff <= '0;
			sys_s2_ff <= '0;
			sys_s3_ff <= '0;
			sys_ff    <= '0;
		end else begin
			sys_s1_ff <= {JOG_ACTIVE, PID_ACTIVE, EXT24_SUPPLY};
			sys_s2_ff <= sys_s1_ff;
			sys_s3_ff <= sys_s2_ff;
			for (int i = 0; i < 3; i++) begin
				if (sys_s2_ff[i] == sys_s3_ff[i]) begin
					sys_ff[i] <= sys_s2_ff[i];
				end
			end
		end
	end
	logic jog, pid, ext24;
	assign {jog, pid, ext24} = sys_ff;

	// Registers
	logic [8:0]  ctrl_ff, nxt_ctrl;
	logic [15:0] maxf_ff, nxt_maxf, extf_ff, nxt_extf;
	logic [15:0] acc_ff, nxt_acc, dec_ff, nxt_dec, acc2_ff, nxt_acc2, dec2_ff, nxt_dec2;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        slverr_ff, nxt_slverr;
	logic        wr, rd, hit, wait_ff, nxt_wait;
	// One wait state: read data is registered in the first access cycle
	assign nxt_wait = PSEL && PENABLE && !wait_ff;
	assign wr = PSEL && PENABLE && PWRITE && wait_ff;
	assign rd = PSEL && PENABLE && !PWRITE && !wait_ff;
	always_comb begin
		case (PADDR)
			RSF_A_CTRL, RSF_A_MAXF, RSF_A_TIMES, RSF_A_TIMES2, RSF_A_EXTF: hit = 1'b1;
			RSF_A_REMF, RSF_A_STORED, RSF_A_STATUS, RSF_A_RAMP: hit = !PWRITE;
			default: hit = 1'b0;
		endcase
	end

	logic [1:0]  sel;
	logic [2:0]  opmode;
	logic        netmode, remote_on, store_en;
	assign sel     = ctrl_ff[RSF_CTRL_SEL_HI:RSF_CTRL_SEL_LO];
	assign opmode  = ctrl_ff[RSF_CTRL_MODE_HI:RSF_CTRL_MODE_LO];
	assign netmode = ctrl_ff[RSF_CTRL_NET];
	assign remote_on = (sel != RSF_SEL_MULTI) && !jog && !pid;
	assign store_en  = (sel == RSF_SEL_STORE) && remote_on;
	assign MULTI_SPEED_EN = (sel == RSF_SEL_MULTI);

	// Remote frequency state
	logic [15:0] remf_ff, nxt_remf, stored_ff, nxt_stored, nvm_wd_ff, nxt_nvm_wd;
	logic        nvm_we_ff, nxt_nvm_we, loaded_ff, nxt_loaded;
	logic        fwd_d_ff, rev_d_ff, ext_d_ff;
	logic [39:0] min_ff, nxt_min;
	logic [31:0] tick_ff, nxt_tick;
	logic        tick, start_off, both_off, ext_rise, idle, store_req;
	logic [15:0] ramp, ramp_acc, ramp_dec;
	logic [15:0] rcnt_ff, nxt_rcnt;
	logic [16:0] total;
	logic [15:0] main_f;

	assign tick      = (tick_ff == TDIV);
	assign start_off = (fwd_d_ff && !fwd) || (rev_d_ff && !rev);
	assign both_off  = start_off && !fwd && !rev;
	assign ext_rise  = ext24 && !ext_d_ff && (fwd || rev);
	assign idle      = !up && !dn;
	assign ramp_acc  = sec ? acc2_ff : ((acc_ff > acc2_ff) ? acc_ff : acc2_ff);
	assign ramp_dec  = sec ? dec2_ff : ((dec_ff > dec2_ff) ? dec_ff : dec2_ff);
	assign ramp      = dn ? ramp_dec : ramp_acc;
	assign store_req = store_en && (start_off || ext_rise);

	always_comb begin
		nxt_ctrl   = ctrl_ff;
		nxt_maxf   = maxf_ff;
		nxt_extf   = extf_ff;
		nxt_acc    = acc_ff;
		nxt_dec    = dec_ff;
		nxt_acc2   = acc2_ff;
		nxt_dec2   = dec2_ff;
		nxt_prdata = prdata_ff;
		nxt_slverr = 1'b0;
		if (wr) begin
			case (PADDR)
				RSF_A_CTRL:   nxt_ctrl = PWDATA[8:0];
				RSF_A_MAXF:   nxt_maxf = PWDATA[15:0];
				RSF_A_TIMES:  begin
					nxt_acc = PWDATA[15:0];
					nxt_dec = PWDATA[31:16];
				end
				RSF_A_TIMES2: begin
					nxt_acc2 = PWDATA[15:0];
					nxt_dec2 = PWDATA[31:16];
				end
				RSF_A_EXTF:   nxt_extf = PWDATA[15:0];
				default:      nxt_extf = extf_ff;
			endcase
			nxt_slverr = !hit;
		end else if (rd) begin
			case (PADDR)
				RSF_A_CTRL:   nxt_prdata = {23'h0, ctrl_ff};
				RSF_A_MAXF:   nxt_prdata = {16'h0, maxf_ff};
				RSF_A_TIMES:  nxt_prdata = {dec_ff, acc_ff};
				RSF_A_TIMES2: nxt_prdata = {dec2_ff, acc2_ff};
				RSF_A_EXTF:   nxt_prdata = {16'h0, extf_ff};
				RSF_A_REMF:   nxt_prdata = {16'h0, remf_ff};
				RSF_A_STORED: nxt_prdata = {16'h0, stored_ff};
				RSF_A_STATUS: nxt_prdata = {26'h0, store_en, remote_on, fwd, rev, up, dn};
				RSF_A_RAMP:   nxt_prdata = {16'h0, ramp};
				default: begin
					nxt_prdata = 32'h0;
				end
			endcase
			nxt_slverr = !hit;
		end
	end

	always_comb begin
		nxt_remf   = remf_ff;
		nxt_stored = stored_ff;
		nxt_nvm_we = 1'b0;
		nxt_nvm_wd = nvm_wd_ff;
		nxt_loaded = 1'b1;
		nxt_tick   = tick ? 32'h0 : tick_ff + 32'h1;
		nxt_rcnt   = rcnt_ff;
		nxt_min    = min_ff;
		if (!loaded_ff) begin
			nxt_remf = (sel == RSF_SEL_STORE) ? NVM_RDATA : 16'h0;
		end else if (remote_on) begin
			if (clr) begin
				nxt_remf = 16'h0;
			end else if (remf_ff > maxf_ff) begin
				nxt_remf = maxf_ff;
			end else if ((up ^ dn) && tick) begin
				if (rcnt_ff >= ramp) begin
					nxt_rcnt = 16'h0;
					if (up && remf_ff < maxf_ff) begin
						nxt_remf = remf_ff + RSF_STEP;
					end else if (dn && remf_ff != 16'h0) begin
						nxt_remf = remf_ff - RSF_STEP;
					end
				end else begin
					nxt_rcnt = rcnt_ff + 16'h1;
				end
			end
			if (sel == RSF_SEL_CLRSTOP && both_off) begin
				nxt_remf = 16'h0;
			end
		end
		if (!idle || !store_en) begin
			nxt_min = 40'h0;
		end else if (min_ff == MIN_CNT) begin
			nxt_min = 40'h0;
			if (remf_ff != stored_ff) begin
				nxt_stored = remf_ff;
				nxt_nvm_wd = remf_ff;
				nxt_nvm_we = 1'b1;
			end
		end else begin
			nxt_min = min_ff + 40'h1;
		end
		if (store_req) begin
			nxt_stored = remf_ff;
			nxt_nvm_wd = remf_ff;
			nxt_nvm_we = 1'b1;
		end
	end

	assign main_f = ((opmode == RSF_MODE_EXT) || (opmode == RSF_MODE_COMB4) || netmode)
		? extf_ff : 16'h0;
	assign total  = {1'b0, main_f} + {1'b0, (remote_on ? remf_ff : 16'h0)};
	logic [15:0] freq_ff, nxt_freq, ramp_ff;
	always_comb begin
		nxt_freq = total[16] ? 16'hFFFF : total[15:0];
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_ff   <= '0;
			maxf_ff   <= RSF_MAXF_RST;
			extf_ff   <= '0;
			acc_ff    <= RSF_TIME_RST;
			dec_ff    <= RSF_TIME_RST;
			acc2_ff   <= RSF_TIME_RST;
			dec2_ff   <= RSF_TIME_RST;
			prdata_ff <= '0;
			slverr_ff <= 1'b0;
			wait_ff   <= 1'b0;
			remf_ff   <= '0;
			stored_ff <= '0;
			nvm_we_ff <= 1'b0;
			nvm_wd_ff <= '0;
			loaded_ff <= 1'b0;
			fwd_d_ff  <= 1'b0;
			rev_d_ff  <= 1'b0;
			ext_d_ff  <= 1'b0;
			min_ff    <= '0;
			tick_ff   <= '0;
			rcnt_ff   <= '0;
			freq_ff   <= '0;
			ramp_ff   <= '0;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			maxf_ff   <= nxt_maxf;
			extf_ff   <= nxt_extf;
			acc_ff    <= nxt_acc;
			dec_ff    <= nxt_dec;
			acc2_ff   <= nxt_acc2;
			dec2_ff   <= nxt_dec2;
			prdata_ff <= nxt_prdata;
			slverr_ff <= nxt_slverr;
			wait_ff   <= nxt_wait;
			remf_ff   <= nxt_remf;
			stored_ff <= loaded_ff ? nxt_stored : NVM_RDATA;
			nvm_we_ff <= nxt_nvm_we;
			nvm_wd_ff <= nxt_nvm_wd;
			loaded_ff <= nxt_loaded;
			fwd_d_ff  <= fwd;
			rev_d_ff  <= rev;
			ext_d_ff  <= ext24;
			min_ff    <= nxt_min;
			tick_ff   <= nxt_tick;
			rcnt_ff   <= nxt_rcnt;
			freq_ff   <= nxt_freq;
			ramp_ff   <= ramp;
		end
	end

	assign PREADY    = wait_ff;
	assign PRDATA    = prdata_ff;
	assign PSLVERR   = PSEL && PENABLE && wait_ff && !hit;
	assign NVM_WE    = nvm_we_ff;
	assign NVM_WDATA = nvm_wd_ff;
	assign FREQ_CMD  = freq_ff;
	assign RAMP_TIME = ramp_ff;

	AST_STORE_ON_STOP: assert property (@(posedge CLK) disable iff (!RSTN)
		store_req |=> NVM_WE && NVM_WDATA == $past(remf_ff)) else $error("no store on stop");
	AST_NO_STORE_SEL2: assert property (@(posedge CLK) disable iff (!RSTN)
		(sel != RSF_SEL_STORE) && loaded_ff |=> !NVM_WE) else $error("store without enable");
	AST_LIMIT: assert property (@(posedge CLK) disable iff (!RSTN)
		loaded_ff && $stable(maxf_ff) && remf_ff <= maxf_ff |=> remf_ff <= maxf_ff)
		else $error("remote frequency above max");
	AST_RAMP_SEC: assert property (@(posedge CLK) disable iff (!RSTN)
		sec && !dn |=> RAMP_TIME == $past(acc2_ff)) else $error("ramp not second time");
	AST_RAMP_LONG: assert property (@(posedge CLK) disable iff (!RSTN)
		!sec && !dn |=> RAMP_TIME >= $past(acc2_ff) && RAMP_TIME >= $past(acc_ff))
		else $error("ramp not longer time");
	AST_CLR3: assert property (@(posedge CLK) disable iff (!RSTN)
		loaded_ff && remote_on && sel == RSF_SEL_CLRSTOP && both_off |=> remf_ff == 16'h0)
		else $error("sel 3 not cleared");
	AST_JOG_OFF: assert property (@(posedge CLK) disable iff (!RSTN)
		(jog || pid) && loaded_ff |=> $stable(remf_ff)) else $error("remote active in jog");
	AST_MULTI: assert property (@(posedge CLK) disable iff (!RSTN)
		MULTI_SPEED_EN == (sel == RSF_SEL_MULTI)) else $error("multi-speed not gated");
	AST_CLEAR: assert property (@(posedge CLK) disable iff (!RSTN)
		loaded_ff && remote_on && clr |=> remf_ff == 16'h0) else $error("clear ignored");
endmodule : rsf_top
`default_nettype wire

// ### dv/rsf_contacts.sv
// Model of the operator contact switches and start inputs.
// Assumes the bench sets the wanted levels right after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module rsf_contacts (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Wanted and presented contact levels
	input  wire logic [8:0] want,
	output logic      [8:0] lv
);
	// Contacts change only on a clock edge, like a scanned switch panel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lv <= 9'h000;
		end else begin
			lv <= want;
		end
	end
endmodule : rsf_contacts
`default_nettype wire

// ### dv/remote_speed_setting_bench.sv
// Bench for rsf_top: register access, contact commands, storage timing.
// Assumes rsf_contacts drives the contact and start levels.
`timescale 1ns/100ps
`default_nettype none
module remote_speed_setting_bench;
	import rsf_pkg::*;
	localparam logic [8:0] UP = 9'h001, DN = 9'h002, CLR = 9'h004, FWD = 9'h008;
	localparam logic [8:0] JOG = 9'h040, PID = 9'h080, EXT = 9'h100;
	logic        clk, rstn, psel, penable, pwrite, pslverr, pready, nvm_we, mse, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] nvm_rd, nvm_wd, freq, ramp, we_dat, ef, a1, d1, a2, d2;
	logic [8:0]  want, lv;
	int          err_total, cmp_count, c0;
	int          we_cnt = 0;
	rsf_contacts rsf_contacts_inst (.clk(clk), .rst_n(rstn), .want(want), .lv(lv));
	rsf_top #(.MINUTE_CYC(200), .TICK_DIV(4)) rsf_top_inst (
		.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .UP_INPUT(lv[0]), .DOWN_INPUT(lv[1]), .CLEAR_INPUT(lv[2]),
		.FWD_START(lv[3]), .REV_START(lv[4]), .SECOND_ACCEL_SELECT(lv[5]),
		.JOG_ACTIVE(lv[6]), .PID_ACTIVE(lv[7]), .EXT24_SUPPLY(lv[8]),
		.NVM_RDATA(nvm_rd), .NVM_WE(nvm_we), .NVM_WDATA(nvm_wd), .FREQ_CMD(freq),
		.RAMP_TIME(ramp), .MULTI_SPEED_EN(mse));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(negedge clk) begin
		if (rstn && nvm_we === 1'b1) begin
			we_cnt++;
			we_dat = nvm_wd;
		end
	end
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			complete_run();
		end
		e = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic wait_remf(input logic [15:0] v);
		int n;
		n = 0;
		do begin
			rd(RSF_A_REMF);
			n++;
		end while (q[15:0] !== v && n < 200);
		chk(q, {16'h0, v});
	endtask : wait_remf
	function automatic logic [31:0] ctl(input logic [1:0] s, input logic [2:0] m, input logic n);
		return {23'h0, n, 1'b0, m, 2'h0, s};
	endfunction : ctl
	function automatic logic [15:0] pick(input logic [15:0] n, s, input logic r);
		return (r || s > n) ? s : n;
	endfunction : pick
	initial begin
		{psel, penable, pwrite, paddr, pwdata, want} = '0;
		rstn = 1'b0;
		nvm_rd = 16'h0ABC;
		err_total = 0;
		cmp_count = 0;
		q = $urandom(72639);
		cyc(5);
		rstn <= 1'b1;
		cyc(2);
		rd(RSF_A_MAXF);
		chk(q, {16'h0, RSF_MAXF_RST});
		rd(RSF_A_STORED);
		chk(q, 32'h0ABC);
		chk(mse, 1'b1);
		rd(8'h3C);
		chk({e, q[30:0]}, 32'h80000000);
		// Ramp time selection for each input and selector state
		{a1, d1, a2, d2} = {16'($urandom % 8), 16'($urandom % 8), 16'($urandom % 8), 16'($urandom % 8)};
		wr(RSF_A_TIMES, {d1, a1});
		wr(RSF_A_TIMES2, {d2, a2});
		wr(RSF_A_CTRL, ctl(2'h2, RSF_MODE_EXT, 1'b0));
		chk(mse, 1'b0);
		for (int i = 0; i < 4; i++) begin
			want <= {3'h0, i[1], 3'h0, i[0], ~i[0]};
			cyc(12);
			chk(ramp, i[0] ? pick(d1, d2, i[1]) : pick(a1, a2, i[1]));
		end
		want <= 9'h000;
		wr(RSF_A_TIMES, 32'h0);
		wr(RSF_A_TIMES2, 32'h0);
		wr(RSF_A_MAXF, 32'h14);
		want <= UP;
		wait_remf(16'h14);
		cyc(40);
		wait_remf(16'h14);
		want <= DN;
		wait_remf(16'h0);
		cyc(40);
		wait_remf(16'h0);
		// Random bursts keep the frequency inside its range
		for (int i = 0; i < 20; i++) begin
			want <= 9'($urandom % 4);
			cyc($urandom % 40);
			rd(RSF_A_REMF);
			chk(q[15:0] <= 16'h14, 1'b1);
		end
		want <= UP;
		wait_remf(16'h14);
		want <= CLR;
		cyc(12);
		wait_remf(16'h0);
		want <= UP;
		wait_remf(16'h14);
		ef = 16'($urandom % 16'hF000);
		wr(RSF_A_EXTF, {16'h0, ef});
		want <= 9'h000;
		for (int i = 0; i < 4; i++) begin
			wr(RSF_A_CTRL, ctl(2'h2, i[1] ? 3'h0 : (i[0] ? RSF_MODE_COMB4 : RSF_MODE_EXT), i == 2));
			cyc(8);
			chk(freq, i == 3 ? 16'h14 : ef + 16'h14);
		end
		wr(RSF_A_CTRL, ctl(2'h2, RSF_MODE_EXT, 1'b0));
		want <= JOG | DN;
		cyc(40);
		chk(freq, ef);
		wait_remf(16'h14);
		want <= PID;
		cyc(12);
		chk(freq, ef);
		// Selection 2 keeps the frequency and never stores it
		want <= FWD;
		cyc(12);
		c0 = we_cnt;
		want <= 9'h000;
		cyc(20);
		chk(we_cnt, c0);
		wait_remf(16'h14);
		want <= UP;
		wr(RSF_A_CTRL, ctl(RSF_SEL_STORE, RSF_MODE_EXT, 1'b0));
		want <= UP | FWD;
		cyc(12);
		c0 = we_cnt;
		want <= 9'h000;
		cyc(20);
		chk(we_cnt, c0 + 1);
		chk(we_dat, 16'h14);
		want <= CLR;
		cyc(12);
		wait_remf(16'h0);
		c0 = we_cnt;
		for (int n = 0; n < 300 && we_cnt == c0; n++) cyc(1);
		chk(we_cnt, c0 + 1);
		chk(we_dat, 16'h0);
		c0 = we_cnt;
		cyc(450);
		chk(we_cnt, c0);
		want <= FWD;
		cyc(12);
		c0 = we_cnt;
		want <= FWD | EXT;
		cyc(12);
		chk(we_cnt, c0 + 1);
		want <= 9'h000;
		wr(RSF_A_CTRL, ctl(RSF_SEL_CLRSTOP, RSF_MODE_EXT, 1'b0));
		want <= UP;
		wait_remf(16'h14);
		want <= FWD;
		cyc(12);
		c0 = we_cnt;
		want <= 9'h000;
		cyc(20);
		wait_remf(16'h0);
		chk(we_cnt, c0);
		complete_run();
	end
endmodule : remote_speed_setting_bench
`default_nettype wire
